// [rtl/special_cycle_pkg.sv]
// package of constants and carrier types for the special-cycle decoder
package special_cycle_pkg;
   // request phase codes identifying a special cycle
   localparam logic [4:0] REQ_A_SPECIAL   = 5'h08;
   localparam logic [2:0] REQ_B_SPECIAL   = 3'h1;
   // special cycle type codes
   localparam logic [7:0] TYPE_NOP        = 8'h00;
   localparam logic [7:0] TYPE_SHUTDOWN   = 8'h01;
   localparam logic [7:0] TYPE_FLUSH      = 8'h02;
   localparam logic [7:0] TYPE_HALT       = 8'h03;
   localparam logic [7:0] TYPE_SYNC       = 8'h04;
   localparam logic [7:0] TYPE_FLUSH_ACK  = 8'h05;
   localparam logic [7:0] TYPE_STOP_ACK   = 8'h06;
   localparam logic [7:0] TYPE_SYSMGMT    = 8'h07;
   // downstream special cycle codes
   localparam logic [1:0] DOWN_SHUTDOWN   = 2'h0;
   localparam logic [1:0] DOWN_HALT       = 2'h1;
   localparam logic [1:0] DOWN_STOP_GRANT = 2'h2;
   // reset value of the system management window bit
   localparam logic       SYSMGMT_RESET   = 1'b0;

   // one decoded host request
   typedef struct packed {
      logic [4:0]  request_code_first_phase;
      logic [4:0]  request_code_second_phase;
      logic [32:0] address_first_phase;
      logic [7:0]  special_type_field;
      logic        sysmgmt_space_select_bit;
   } host_request_t;

   // classification of a special cycle
   typedef enum logic [2:0] {
      ACT_NONE     = 3'h0,
      ACT_LOCAL    = 3'h1,
      ACT_FORWARD  = 3'h2,
      ACT_SM_ENTER = 3'h3,
      ACT_SM_EXIT  = 3'h4
   } action_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_FORWARD = 2'b11,
      ST_WAIT    = 2'b01,
      ST_RETIRE  = 2'b10
   } state_t;
endpackage

// [rtl/special_type_classify.sv]
// combinational decode of a special cycle request into an action
`timescale 1ns/100ps
module special_type_classify (
   input  wire special_cycle_pkg::host_request_t req,
   output special_cycle_pkg::action_t             action,
   output logic [1:0]                             down_code,
   output logic                                   is_special
);
   // match the request codes; the first address phase is never looked at
   always_comb begin
      is_special = (req.request_code_first_phase == special_cycle_pkg::REQ_A_SPECIAL) &&
                   (req.request_code_second_phase[2:0] == special_cycle_pkg::REQ_B_SPECIAL);
      down_code  = special_cycle_pkg::DOWN_SHUTDOWN;
      action     = special_cycle_pkg::ACT_NONE;
      case (req.special_type_field)
         special_cycle_pkg::TYPE_SHUTDOWN: begin
            action    = special_cycle_pkg::ACT_FORWARD;
            down_code = special_cycle_pkg::DOWN_SHUTDOWN;
         end
         special_cycle_pkg::TYPE_HALT: begin
            action    = special_cycle_pkg::ACT_FORWARD;
            down_code = special_cycle_pkg::DOWN_HALT;
         end
         special_cycle_pkg::TYPE_STOP_ACK: begin
            action    = special_cycle_pkg::ACT_FORWARD;
            down_code = special_cycle_pkg::DOWN_STOP_GRANT;
         end
         special_cycle_pkg::TYPE_FLUSH,
         special_cycle_pkg::TYPE_SYNC,
         special_cycle_pkg::TYPE_FLUSH_ACK: begin
            action = special_cycle_pkg::ACT_LOCAL;
         end
         special_cycle_pkg::TYPE_SYSMGMT: begin
            action = req.sysmgmt_space_select_bit ? special_cycle_pkg::ACT_SM_ENTER
                                                  : special_cycle_pkg::ACT_SM_EXIT;
         end
         default: begin
            action = special_cycle_pkg::ACT_NONE; // nop and undefined codes
         end
      endcase
   end
endmodule

// [rtl/sysmgmt_window.sv]
// holder for the system management window state bit
`timescale 1ns/100ps
module sysmgmt_window (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic open_req,
   input  wire logic close_req,
   output logic      window_open
);
   logic open_reg;
   logic open_next;

   // next value: open on entry, close on exit
   always_comb begin
      open_next = open_reg;
      if (open_req) begin
         open_next = 1'b1;
      end else if (close_req) begin
         open_next = 1'b0;
      end
   end

   // register with reset to closed
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         open_reg <= special_cycle_pkg::SYSMGMT_RESET;
      end else begin
         open_reg <= open_next;
      end
   end

   assign window_open = open_reg;
endmodule

// [rtl/host_special_cycle_decoder.sv]
// special-cycle decoder between the host bus and the downstream hub link
`timescale 1ns/100ps
module host_special_cycle_decoder (
   input  wire logic                             clk,
   input  wire logic                             sys_rst,
   input  wire logic                             req_valid,
   input  wire special_cycle_pkg::host_request_t req,
   input  wire logic                             down_master_abort,
   output logic                                  req_ready,
   output logic                                  claim,
   output logic                                  retire,
   output logic                                  down_valid,
   output logic [1:0]                            down_code,
   output logic                                  sysmgmt_access,
   output logic                                  system_management_mode
);
   special_cycle_pkg::action_t action;
   logic [1:0]                 cls_code;
   logic                       is_special;
   logic                       win_open;
   logic                       sm_open_req;
   logic                       sm_close_req;

   special_cycle_pkg::state_t  state_reg;
   special_cycle_pkg::state_t  state_next;
   logic                       claim_reg;
   logic                       claim_next;
   logic                       retire_reg;
   logic                       retire_next;
   logic                       down_valid_reg;
   logic                       down_valid_next;
   logic [1:0]                 down_code_reg;
   logic [1:0]                 down_code_next;
   logic                       smacc_reg;
   logic                       smacc_next;
   logic                       ready_reg;
   logic                       ready_next;
   logic                       take;
   logic                       special_take;
   logic                       fwd_take;
   logic                       plain_take;

   special_type_classify u_classify (
      .req        (req),
      .action     (action),
      .down_code  (cls_code),
      .is_special (is_special)
   );

   sysmgmt_window u_window (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .open_req    (sm_open_req),
      .close_req   (sm_close_req),
      .window_open (win_open)
   );

   assign take         = req_valid && ready_reg;
   // qualified takes, watched by the checks below
   assign special_take = take && is_special;
   assign fwd_take     = special_take && (action == special_cycle_pkg::ACT_FORWARD);
   assign plain_take   = take && !is_special;
   // window updates only on a matching special cycle
   assign sm_open_req  = take && is_special &&
                         (action == special_cycle_pkg::ACT_SM_ENTER);
   assign sm_close_req = take && is_special &&
                         (action == special_cycle_pkg::ACT_SM_EXIT);

   // next-state and output computation
   always_comb begin
      state_next      = state_reg;
      claim_next      = 1'b0;
      retire_next     = 1'b0;
      down_valid_next = 1'b0;
      down_code_next  = down_code_reg;
      ready_next      = ready_reg;
      smacc_next      = 1'b0;
      unique case (state_reg)
         special_cycle_pkg::ST_IDLE: begin
            if (take && is_special) begin
               claim_next = 1'b1;
               unique case (action)
                  special_cycle_pkg::ACT_FORWARD: begin
                     down_valid_next = 1'b1;
                     down_code_next  = cls_code;
                     ready_next      = 1'b0;
                     state_next      = special_cycle_pkg::ST_WAIT;
                  end
                  default: begin
                     retire_next = 1'b1;
                  end
               endcase
            end else if (take) begin
               // later accesses with the select bit decode to the window
               smacc_next = win_open && req.sysmgmt_space_select_bit;
            end
         end
         special_cycle_pkg::ST_WAIT: begin
            if (down_master_abort) begin
               retire_next = 1'b1;
               ready_next  = 1'b1;
               state_next  = special_cycle_pkg::ST_IDLE;
            end
         end
         default: begin
            ready_next = 1'b1;
            state_next = special_cycle_pkg::ST_IDLE;
         end
      endcase
   end

   // registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg      <= special_cycle_pkg::ST_IDLE;
         claim_reg      <= 1'b0;
         retire_reg     <= 1'b0;
         down_valid_reg <= 1'b0;
         down_code_reg  <= special_cycle_pkg::DOWN_SHUTDOWN;
         smacc_reg      <= 1'b0;
         ready_reg      <= 1'b1;
      end else begin
         state_reg      <= state_next;
         claim_reg      <= claim_next;
         retire_reg     <= retire_next;
         down_valid_reg <= down_valid_next;
         down_code_reg  <= down_code_next;
         smacc_reg      <= smacc_next;
         ready_reg      <= ready_next;
      end
   end

   assign req_ready              = ready_reg;
   assign claim                  = claim_reg;
   assign retire                 = retire_reg;
   assign down_valid             = down_valid_reg;
   assign down_code              = down_code_reg;
   assign sysmgmt_access         = smacc_reg;
   assign system_management_mode = win_open;

   // assertions
   property p_forward_only_valid;
      @(posedge clk) disable iff (sys_rst)
      down_valid |-> $past(fwd_take);
   endproperty
   a_forward_only_valid: assert property (p_forward_only_valid)
      else $error("downstream cycle without forwarding type");

   property p_local_retire;
      @(posedge clk) disable iff (sys_rst)
      (take && is_special && action != special_cycle_pkg::ACT_FORWARD)
         |=> (retire && claim && !down_valid);
   endproperty
   a_local_retire: assert property (p_local_retire)
      else $error("local type not retired next cycle");

   property p_fwd_no_early_retire;
      @(posedge clk) disable iff (sys_rst)
      (state_reg == special_cycle_pkg::ST_WAIT && !down_master_abort) |=> !retire;
   endproperty
   a_fwd_no_early_retire: assert property (p_fwd_no_early_retire)
      else $error("forwarded cycle retired before master abort");

   property p_abort_retire;
      @(posedge clk) disable iff (sys_rst)
      (state_reg == special_cycle_pkg::ST_WAIT && down_master_abort) |=> (retire && req_ready);
   endproperty
   a_abort_retire: assert property (p_abort_retire)
      else $error("master abort did not retire");

   property p_stop_grant_code;
      @(posedge clk) disable iff (sys_rst)
      (take && is_special && req.special_type_field == special_cycle_pkg::TYPE_STOP_ACK)
         |=> (down_valid && down_code == special_cycle_pkg::DOWN_STOP_GRANT);
   endproperty
   a_stop_grant_code: assert property (p_stop_grant_code)
      else $error("stop grant not forwarded");

   property p_sm_enter;
      @(posedge clk) disable iff (sys_rst)
      sm_open_req |=> system_management_mode;
   endproperty
   a_sm_enter: assert property (p_sm_enter)
      else $error("window did not open");

   property p_sm_exit;
      @(posedge clk) disable iff (sys_rst)
      sm_close_req |=> !system_management_mode;
   endproperty
   a_sm_exit: assert property (p_sm_exit)
      else $error("window did not close");

   property p_nop_quiet;
      @(posedge clk) disable iff (sys_rst)
      (take && is_special && req.special_type_field == special_cycle_pkg::TYPE_NOP)
         |=> ($stable(system_management_mode) && !down_valid);
   endproperty
   a_nop_quiet: assert property (p_nop_quiet)
      else $error("nop had a side effect");

   property p_window_access;
      @(posedge clk) disable iff (sys_rst)
      sysmgmt_access |-> $past(win_open);
   endproperty
   a_window_access: assert property (p_window_access)
      else $error("window access while window closed");

   // a claim only ever follows a taken special cycle
   property p_claim_special;
      @(posedge clk) disable iff (sys_rst)
      claim |-> $past(special_take);
   endproperty
   a_claim_special: assert property (p_claim_special)
      else $error("claim without a special cycle");

   // an ordinary request is never claimed, retired or forwarded here
   property p_plain_quiet;
      @(posedge clk) disable iff (sys_rst)
      plain_take |=> (!claim && !retire && !down_valid);
   endproperty
   a_plain_quiet: assert property (p_plain_quiet)
      else $error("ordinary request handled as special cycle");

   // the host side is held off for the whole wait on the downstream link
   property p_wait_not_ready;
      @(posedge clk) disable iff (sys_rst)
      (state_reg == special_cycle_pkg::ST_WAIT) |-> !req_ready;
   endproperty
   a_wait_not_ready: assert property (p_wait_not_ready)
      else $error("request accepted while waiting on master abort");

   // shutdown goes downstream with its own code
   property p_shutdown_code;
      @(posedge clk) disable iff (sys_rst)
      (special_take && req.special_type_field == special_cycle_pkg::TYPE_SHUTDOWN)
         |=> (down_valid && down_code == special_cycle_pkg::DOWN_SHUTDOWN);
   endproperty
   a_shutdown_code: assert property (p_shutdown_code)
      else $error("shutdown not forwarded");

   // halt goes downstream with its own code
   property p_halt_code;
      @(posedge clk) disable iff (sys_rst)
      (special_take && req.special_type_field == special_cycle_pkg::TYPE_HALT)
         |=> (down_valid && down_code == special_cycle_pkg::DOWN_HALT);
   endproperty
   a_halt_code: assert property (p_halt_code)
      else $error("halt not forwarded");

   // a locally retired cycle frees the host side at once
   property p_local_ready;
      @(posedge clk) disable iff (sys_rst)
      (special_take && !fwd_take)
         |=> (req_ready && state_reg == special_cycle_pkg::ST_IDLE);
   endproperty
   a_local_ready: assert property (p_local_ready)
      else $error("local cycle left the host side waiting");

   // the window bit moves only on a management special cycle
   property p_window_steady;
      @(posedge clk) disable iff (sys_rst)
      (!sm_open_req && !sm_close_req) |=> $stable(system_management_mode);
   endproperty
   a_window_steady: assert property (p_window_steady)
      else $error("window changed without a management cycle");

   // window accesses come only from ordinary requests
   property p_access_plain;
      @(posedge clk) disable iff (sys_rst)
      sysmgmt_access |-> $past(plain_take);
   endproperty
   a_access_plain: assert property (p_access_plain)
      else $error("window access from a special cycle");

   // with the window open, every select-bit access is steered into it
   property p_access_select;
      @(posedge clk) disable iff (sys_rst)
      (plain_take && system_management_mode && req.sysmgmt_space_select_bit)
         |=> sysmgmt_access;
   endproperty
   a_access_select: assert property (p_access_select)
      else $error("select-bit access missed the open window");

   // cover points for the main scenarios
   c_shutdown: cover property (@(posedge clk) disable iff (sys_rst)
      down_valid && down_code == special_cycle_pkg::DOWN_SHUTDOWN ##[1:20] retire);
   c_halt: cover property (@(posedge clk) disable iff (sys_rst)
      down_valid && down_code == special_cycle_pkg::DOWN_HALT);
   c_sm_round: cover property (@(posedge clk) disable iff (sys_rst)
      sm_open_req ##[1:50] sm_close_req);
   c_sm_access: cover property (@(posedge clk) disable iff (sys_rst) sysmgmt_access);
   c_local: cover property (@(posedge clk) disable iff (sys_rst) claim && retire);
endmodule

// [verif/hub_link_model.sv]
// downstream hub link model that ends each forwarded special cycle by master abort
`timescale 1ns/100ps
module hub_link_model (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       down_valid,
   input  wire logic [7:0] abort_delay,
   output logic            down_master_abort
);
   logic [7:0] wait_reg;
   logic       busy_reg;

   // wait abort_delay cycles after each forwarded cycle, then pulse master abort
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wait_reg          <= 8'h00;
         busy_reg          <= 1'b0;
         down_master_abort <= 1'b0;
      end else begin
         down_master_abort <= 1'b0;
         if (down_valid) begin
            busy_reg <= 1'b1;
            wait_reg <= abort_delay;
         end else if (busy_reg) begin
            if (wait_reg == 8'h00) begin
               down_master_abort <= 1'b1;
               busy_reg          <= 1'b0;
            end else begin
               wait_reg <= wait_reg - 8'h01;
            end
         end
      end
   end
endmodule

// [verif/testbench.sv]
// self-checking bench for the special-cycle decoder with a downstream link model
`timescale 1ns/100ps
`define CHECK(name, exp, got) begin compares++; if ((got) !== (exp)) begin \
   $display("wrong value %s expected %h seen %h", name, exp, got); mismatches++; end end
module testbench;
   typedef struct {
      logic [4:0] cb;
      logic [7:0] ty;
      logic       sel;
      logic       fwd;
      logic [1:0] code;
      logic       mode;
   } row_t;
   logic                             clk = 1'b0;
   logic                             sys_rst = 1'b1;
   logic                             req_valid = 1'b0;
   special_cycle_pkg::host_request_t req = '0;
   logic                             down_master_abort;
   logic                             req_ready, claim, retire, down_valid;
   logic [1:0]                       down_code;
   logic                             sysmgmt_access, system_management_mode;
   logic [7:0]                       abort_delay = 8'h00;
   int                               mismatches = 0;
   int                               compares = 0;
   int                               cycles = 0;
   row_t                             rows [11];

   host_special_cycle_decoder dut_u (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
      .req(req), .down_master_abort(down_master_abort), .req_ready(req_ready),
      .claim(claim), .retire(retire), .down_valid(down_valid), .down_code(down_code),
      .sysmgmt_access(sysmgmt_access), .system_management_mode(system_management_mode));
   hub_link_model link_u (.clk(clk), .sys_rst(sys_rst), .down_valid(down_valid),
      .abort_delay(abort_delay), .down_master_abort(down_master_abort));

   // 25 MHz clock
   always #20 clk = ~clk;

   // final report and verdict
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         test_done();
      end
   end

   // present one request, hold it until taken, return at the next negedge
   task automatic send(input logic [4:0] ca, input logic [4:0] cb, input logic [7:0] ty,
                       input logic sel, input logic [32:0] adr);
      @(posedge clk);
      req_valid <= 1'b1;
      req       <= '{ca, cb, adr, ty, sel};
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
   endtask

   // wait for the master abort pulse, then expect retirement one cycle later
   task automatic wait_retire;
      for (int i = 0; i < 40 && down_master_abort !== 1'b1; i++) @(negedge clk);
      `CHECK("retire_early", 1'b0, retire)
      @(negedge clk);
      `CHECK("retire", 1'b1, retire)
      `CHECK("ready_after", 1'b1, req_ready)
   endtask

   initial begin
      rows = '{
         '{5'h01, 8'h00, 1'b0, 1'b0, 2'h0, 1'b0}, '{5'h19, 8'h01, 1'b0, 1'b1, 2'h0, 1'b0},
         '{5'h01, 8'h02, 1'b0, 1'b0, 2'h0, 1'b0}, '{5'h09, 8'h03, 1'b1, 1'b1, 2'h1, 1'b0},
         '{5'h01, 8'h04, 1'b0, 1'b0, 2'h0, 1'b0}, '{5'h11, 8'h05, 1'b0, 1'b0, 2'h0, 1'b0},
         '{5'h01, 8'h06, 1'b0, 1'b1, 2'h2, 1'b0}, '{5'h01, 8'h07, 1'b1, 1'b0, 2'h0, 1'b1},
         '{5'h01, 8'h5A, 1'b0, 1'b0, 2'h0, 1'b1}, '{5'h01, 8'h07, 1'b0, 1'b0, 2'h0, 1'b0},
         '{5'h01, 8'hFF, 1'b1, 1'b0, 2'h0, 1'b0}};
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      `CHECK("ready_reset", 1'b1, req_ready)
      `CHECK("mode_reset", special_cycle_pkg::SYSMGMT_RESET, system_management_mode)
      // ordinary cases, prompt and slow master abort alternating
      foreach (rows[i]) begin
         abort_delay <= (i % 2 == 1) ? 8'h0C : 8'h00;
         send(special_cycle_pkg::REQ_A_SPECIAL, rows[i].cb, rows[i].ty, rows[i].sel,
              {11{i[2:0]}});
         `CHECK("claim", 1'b1, claim)
         `CHECK("down_valid", rows[i].fwd, down_valid)
         `CHECK("mode", rows[i].mode, system_management_mode)
         if (rows[i].fwd) begin
            `CHECK("down_code", rows[i].code, down_code)
            `CHECK("ready_wait", 1'b0, req_ready)
            wait_retire();
         end else begin
            `CHECK("retire_local", 1'b1, retire)
         end
      end
      // near misses of the special cycle codes are not claimed
      send(5'h08, 5'h02, special_cycle_pkg::TYPE_FLUSH, 1'b0, 33'h0);
      `CHECK("claim_second", 1'b0, claim)
      send(5'h09, 5'h01, special_cycle_pkg::TYPE_FLUSH, 1'b0, 33'h0);
      `CHECK("claim_first", 1'b0, claim)
      // open window steers later select-bit accesses
      send(5'h08, 5'h01, special_cycle_pkg::TYPE_SYSMGMT, 1'b1, 33'h1FFFFFFFF);
      send(5'h06, 5'h00, 8'h00, 1'b1, 33'h0);
      `CHECK("access_open", 1'b1, sysmgmt_access)
      `CHECK("claim_plain", 1'b0, claim)
      send(5'h06, 5'h00, 8'h00, 1'b0, 33'h0);
      `CHECK("access_nosel", 1'b0, sysmgmt_access)
      // a mid-run reset closes the window
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      `CHECK("mode_rereset", 1'b0, system_management_mode)
      send(5'h06, 5'h00, 8'h00, 1'b1, 33'h0);
      `CHECK("access_closed", 1'b0, sysmgmt_access)
      // a request held while waiting on the abort is refused until retirement
      abort_delay <= 8'h14;
      send(5'h08, 5'h01, special_cycle_pkg::TYPE_STOP_ACK, 1'b0, 33'h0);
      @(posedge clk);
      req_valid <= 1'b1;
      req       <= '{5'h08, 5'h01, 33'h0, special_cycle_pkg::TYPE_SYNC, 1'b0};
      repeat (5) begin
         @(negedge clk);
         `CHECK("claim_refused", 1'b0, claim)
      end
      wait_retire();
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      `CHECK("claim_after", 1'b1, claim)
      `CHECK("down_after", 1'b0, down_valid)
      repeat (2) @(posedge clk);
      test_done();
   end
endmodule
